// ### rtl/lsc_light_sensor_ctrl.sv
// Command decoder, integration timer, result register and two-wire slave of the light sensor.
// Assumes open-drain bus wiring outside, a free-running link sampling clock and a same-clock converter count.
module lsc_light_sensor_ctrl #(
    parameter int unsigned P_OSC_DIV = lsc_pkg::OSC_DIV
) (
    input logic i_sys_clk,
    input logic i_reset,
    input logic i_link_clk,
    input logic i_scl,
    input logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    input logic i_addr_sel,
    input logic [15:0] i_light_level,
    output logic o_powered,
    output logic o_measuring
);
    localparam logic [15:0] OSC_LAST = 16'(P_OSC_DIV - 1);

    function automatic logic is_measure(input logic [7:0] op);
        is_measure = (op[7:4] == lsc_pkg::OP_CONT_GROUP || op[7:4] == lsc_pkg::OP_ONCE_GROUP)
            && op[3:2] == 2'b00 && op[1:0] != 2'b10;
    endfunction : is_measure

    function automatic logic [9:0] ticks_per_mt(input logic [1:0] res);
        ticks_per_mt = (res == lsc_pkg::RES_COARSE) ? lsc_pkg::COARSE_TICKS_PER_MT : lsc_pkg::FINE_TICKS_PER_MT;
    endfunction : ticks_per_mt

    // Count grows with integration length; the step size follows the resolution.
    function automatic logic [15:0] scale(input logic [15:0] level, input logic [7:0] mt, input logic [1:0] res);
        logic [24:0] prod;
        prod = ({9'h000, level} * {17'h0_0000, mt}) / {17'h0_0000, lsc_pkg::MT_RESET};
        if (res == lsc_pkg::RES_EXTRA_FINE)
        begin
            prod = prod << 1;
        end
        else if (res == lsc_pkg::RES_COARSE)
        begin
            prod = prod & ~25'h000_0003;
        end
        scale = (|prod[24:16]) ? 16'hFFFF : prod[15:0];
    endfunction : scale

    // Link domain: bus sampling and slave state.
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, sel_s1, sel_s2;
    lsc_pkg::lsc_link_t link_state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] tx_byte;
    logic [15:0] tx_word;
    logic [1:0] byte_idx;
    logic rw_read, wr_done, master_ack, sda_drive;
    logic [7:0] link_opcode;
    logic cmd_tgl;
    logic res_s1, res_s2, res_d;
    logic [15:0] link_result;

    // System domain.
    lsc_pkg::lsc_state_t state;
    logic cmd_s1, cmd_s2, cmd_d;
    logic [1:0] mode_res;
    logic one_shot;
    logic [7:0] mt;
    logic [7:0] mt_meas;
    logic [15:0] osc_cnt;
    logic osc_tick;
    logic [19:0] integ_cnt;
    logic [19:0] target;
    logic [15:0] result;
    logic res_tgl;
    logic cmd_new, meas_done, clr_cmd;

    wire scl_rise = scl_s2 & ~scl_d;
    wire scl_fall = ~scl_s2 & scl_d;
    wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
    wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
    wire [6:0] own_addr = sel_s2 ? lsc_pkg::ADDR_SEL_HIGH : lsc_pkg::ADDR_SEL_LOW;

    always_ff @(posedge i_link_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3F;
            {sel_s1, sel_s2} <= 2'b00;
        end
        else
        begin
            scl_s1 <= i_scl;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= i_sda_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            sel_s1 <= i_addr_sel;
            sel_s2 <= sel_s1;
        end
    end

    // Result word crosses by toggle; the value is long stable when the toggle arrives.
    always_ff @(posedge i_link_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            {res_s1, res_s2, res_d} <= 3'b000;
            link_result <= lsc_pkg::RESULT_RESET;
        end
        else
        begin
            res_s1 <= res_tgl;
            res_s2 <= res_s1;
            res_d <= res_s2;
            if (res_s2 ^ res_d)
            begin
                link_result <= result;
            end
        end
    end

    always_ff @(posedge i_link_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            link_state <= lsc_pkg::L_IDLE;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            tx_byte <= 8'h00;
            tx_word <= 16'h0000;
            byte_idx <= 2'b00;
            rw_read <= 1'b0;
            wr_done <= 1'b0;
            master_ack <= 1'b0;
            sda_drive <= 1'b0;
            link_opcode <= 8'h00;
            cmd_tgl <= 1'b0;
        end
        else if (bus_start)
        begin
            link_state <= lsc_pkg::L_ADDR;
            bit_cnt <= 4'h0;
            wr_done <= 1'b0;
            sda_drive <= 1'b0;
        end
        else if (bus_stop)
        begin
            link_state <= lsc_pkg::L_IDLE;
            sda_drive <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (link_state == lsc_pkg::L_ADDR || link_state == lsc_pkg::L_WRITE)
            begin
                shift_in <= {shift_in[6:0], sda_s2};
                bit_cnt <= bit_cnt + 4'h1;
            end
            else if (link_state == lsc_pkg::L_READ)
            begin
                bit_cnt <= bit_cnt + 4'h1;
            end
            else if (link_state == lsc_pkg::L_MASTER_ACK)
            begin
                master_ack <= ~sda_s2;
            end
        end
        else if (scl_fall)
        begin
            case (link_state)
                lsc_pkg::L_ADDR:
                begin
                    if (bit_cnt == 4'h8)
                    begin
                        if (shift_in[7:1] == own_addr)
                        begin
                            link_state <= lsc_pkg::L_ACK_ADDR;
                            rw_read <= shift_in[0];
                            sda_drive <= 1'b1;
                        end
                        else
                        begin
                            link_state <= lsc_pkg::L_IDLE;
                        end
                    end
                end
                lsc_pkg::L_ACK_ADDR:
                begin
                    bit_cnt <= 4'h0;
                    if (rw_read)
                    begin
                        // Snapshot keeps both bytes of one read from the same result.
                        tx_word <= link_result;
                        tx_byte <= link_result[15:8];
                        byte_idx <= 2'b00;
                        sda_drive <= ~link_result[15];
                        link_state <= lsc_pkg::L_READ;
                    end
                    else
                    begin
                        sda_drive <= 1'b0;
                        link_state <= lsc_pkg::L_WRITE;
                    end
                end
                lsc_pkg::L_WRITE:
                begin
                    if (bit_cnt == 4'h8)
                    begin
                        // Only the first byte of a write transfer is taken; later ones get no ack.
                        if (!wr_done)
                        begin
                            link_opcode <= shift_in;
                            cmd_tgl <= ~cmd_tgl;
                            wr_done <= 1'b1;
                            sda_drive <= 1'b1;
                            link_state <= lsc_pkg::L_ACK_WRITE;
                        end
                        else
                        begin
                            link_state <= lsc_pkg::L_IDLE;
                        end
                    end
                end
                lsc_pkg::L_ACK_WRITE:
                begin
                    sda_drive <= 1'b0;
                    bit_cnt <= 4'h0;
                    link_state <= lsc_pkg::L_WRITE;
                end
                lsc_pkg::L_READ:
                begin
                    if (bit_cnt == 4'h8)
                    begin
                        sda_drive <= 1'b0;
                        link_state <= lsc_pkg::L_MASTER_ACK;
                    end
                    else
                    begin
                        sda_drive <= ~tx_byte[3'(4'h7 - bit_cnt)];
                    end
                end
                lsc_pkg::L_MASTER_ACK:
                begin
                    bit_cnt <= 4'h0;
                    if (master_ack)
                    begin
                        tx_byte <= (byte_idx == 2'b00) ? tx_word[7:0] : lsc_pkg::READ_FILL;
                        sda_drive <= (byte_idx == 2'b00) ? ~tx_word[7] : 1'b0;
                        byte_idx <= (byte_idx == 2'b00) ? 2'b01 : 2'b10;
                        link_state <= lsc_pkg::L_READ;
                    end
                    else
                    begin
                        link_state <= lsc_pkg::L_IDLE;
                    end
                end
                default:
                begin
                    link_state <= lsc_pkg::L_IDLE;
                end
            endcase
        end
    end

    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_drive;

    // Command toggle crossing; the opcode itself is stable long before the toggle lands.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            {cmd_s1, cmd_s2, cmd_d} <= 3'b000;
        end
        else
        begin
            cmd_s1 <= cmd_tgl;
            cmd_s2 <= cmd_s1;
            cmd_d <= cmd_s2;
        end
    end

    assign cmd_new = cmd_s2 ^ cmd_d;
    assign clr_cmd = cmd_new && link_opcode == lsc_pkg::OP_CLEAR_RESULT && state != lsc_pkg::ST_DOWN;
    assign meas_done = state == lsc_pkg::ST_MEASURE && osc_tick && integ_cnt == target - 20'h0_0001;

    // Oscillator tick for the integration timer.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            osc_cnt <= 16'h0000;
        end
        else
        begin
            osc_cnt <= (osc_cnt >= OSC_LAST) ? 16'h0000 : osc_cnt + 16'h0001;
        end
    end

    assign osc_tick = osc_cnt >= OSC_LAST;

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state <= lsc_pkg::ST_DOWN;
        end
        else if (cmd_new && link_opcode == lsc_pkg::OP_POWER_DOWN)
        begin
            state <= lsc_pkg::ST_DOWN;
        end
        else if (cmd_new && link_opcode == lsc_pkg::OP_POWER_ON)
        begin
            state <= lsc_pkg::ST_IDLE;
        end
        else if (cmd_new && is_measure(link_opcode))
        begin
            state <= lsc_pkg::ST_MEASURE;
        end
        else if (meas_done && one_shot)
        begin
            state <= lsc_pkg::ST_DOWN;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            mode_res <= lsc_pkg::RES_FINE;
            one_shot <= 1'b0;
            mt_meas <= lsc_pkg::MT_RESET;
            target <= 20'h0_0001;
        end
        else if (cmd_new && is_measure(link_opcode))
        begin
            mode_res <= link_opcode[1:0];
            one_shot <= link_opcode[7:4] == lsc_pkg::OP_ONCE_GROUP;
            mt_meas <= mt;
            target <= {10'h000, ticks_per_mt(link_opcode[1:0])} * {12'h000, mt};
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            mt <= lsc_pkg::MT_RESET;
        end
        else if (cmd_new && link_opcode[7:3] == lsc_pkg::OP_MT_HIGH_PREFIX)
        begin
            mt[7:5] <= link_opcode[2:0];
        end
        else if (cmd_new && link_opcode[7:5] == lsc_pkg::OP_MT_LOW_PREFIX)
        begin
            mt[4:0] <= link_opcode[4:0];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            integ_cnt <= 20'h0_0000;
        end
        else if ((cmd_new && is_measure(link_opcode)) || meas_done || state != lsc_pkg::ST_MEASURE)
        begin
            integ_cnt <= 20'h0_0000;
        end
        else if (osc_tick)
        begin
            integ_cnt <= integ_cnt + 20'h0_0001;
        end
    end

    // A finished measurement wins over a clear arriving in the same cycle.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            result <= lsc_pkg::RESULT_RESET;
            res_tgl <= 1'b0;
        end
        else if (meas_done)
        begin
            result <= scale(i_light_level, mt_meas, mode_res);
            res_tgl <= ~res_tgl;
        end
        else if (clr_cmd)
        begin
            result <= lsc_pkg::RESULT_RESET;
            res_tgl <= ~res_tgl;
        end
    end

    assign o_powered = state != lsc_pkg::ST_DOWN;
    assign o_measuring = state == lsc_pkg::ST_MEASURE;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    power_down_cmd_a: assert property (cmd_new && link_opcode == lsc_pkg::OP_POWER_DOWN |=> !o_powered)
        else $error("power-down opcode did not power down");
    power_on_cmd_a: assert property (cmd_new && link_opcode == lsc_pkg::OP_POWER_ON |=> state == lsc_pkg::ST_IDLE)
        else $error("power-on opcode did not reach idle");
    clear_result_a: assert property (clr_cmd && !meas_done |=> result == lsc_pkg::RESULT_RESET)
        else $error("clear opcode did not zero the result");
    clear_ignored_down_a: assert property (cmd_new && link_opcode == lsc_pkg::OP_CLEAR_RESULT
        && !o_powered |=> $stable(result) && !o_powered)
        else $error("clear opcode acted while powered down");
    measure_start_a: assert property (cmd_new && is_measure(link_opcode)
        |=> o_measuring && integ_cnt == 20'h0_0000 && mode_res == $past(link_opcode[1:0]))
        else $error("measurement opcode did not restart integration");
    one_shot_end_a: assert property (meas_done && one_shot && !cmd_new |=> state == lsc_pkg::ST_DOWN)
        else $error("single measurement did not power down");
    continuous_repeat_a: assert property (meas_done && !one_shot && !cmd_new
        |=> o_measuring && integ_cnt == 20'h0_0000)
        else $error("continuous measurement did not repeat");
    length_high_a: assert property (cmd_new && link_opcode[7:3] == lsc_pkg::OP_MT_HIGH_PREFIX
        |=> mt[7:5] == $past(link_opcode[2:0]) && $stable(mt[4:0]))
        else $error("integration length high bits not loaded");
    result_cause_a: assert property (result != $past(result) |-> $past(meas_done) || $past(clr_cmd))
        else $error("result changed without a cause");
    // The tick comes once every P_OSC_DIV cycles, also for very short dividers.
    osc_tick_gap_a: assert property (osc_tick == (osc_cnt == OSC_LAST)
        && osc_cnt == (($past(osc_cnt) == OSC_LAST) ? 16'h0000 : $past(osc_cnt) + 16'h0001))
        else $error("oscillator tick spacing wrong");

    one_shot_done_c: cover property (meas_done && one_shot ##1 state == lsc_pkg::ST_DOWN);
    two_results_c: cover property (meas_done && !one_shot ##[1:1000] meas_done);
    clear_while_on_c: cover property (clr_cmd);
    restart_c: cover property (o_measuring && cmd_new && is_measure(link_opcode));
endmodule : lsc_light_sensor_ctrl

// ### rtl/lsc_pkg.sv
// Constants, opcodes and state encodings of the light sensor command logic.
// Assumes a 20 MHz system clock standing in for the on-chip oscillator.
package lsc_pkg;
    // Opcodes accepted from the serial bus.
    localparam logic [7:0] OP_POWER_DOWN = 8'h00;
    localparam logic [7:0] OP_POWER_ON = 8'h01;
    localparam logic [7:0] OP_CLEAR_RESULT = 8'h07;
    localparam logic [3:0] OP_CONT_GROUP = 4'h1;
    localparam logic [3:0] OP_ONCE_GROUP = 4'h2;
    localparam logic [4:0] OP_MT_HIGH_PREFIX = 5'h08;
    localparam logic [2:0] OP_MT_LOW_PREFIX = 3'h3;
    // Reset values and bus addresses.
    localparam logic [7:0] MT_RESET = 8'h45;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [6:0] ADDR_SEL_LOW = 7'h23;
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h5C;
    localparam logic [7:0] READ_FILL = 8'hFF;
    // Timing.
    localparam int SYS_CLK_KHZ = 20000;
    localparam int OSC_KHZ = 320;
    localparam int OSC_DIV = SYS_CLK_KHZ / OSC_KHZ;
    localparam int FINE_TIME_MS = 120;
    localparam int COARSE_TIME_MS = 16;
    localparam int FINE_TICKS = FINE_TIME_MS * OSC_KHZ;
    localparam int COARSE_TICKS = COARSE_TIME_MS * OSC_KHZ;
    localparam logic [9:0] FINE_TICKS_PER_MT = 10'(FINE_TICKS / int'(MT_RESET));
    localparam logic [9:0] COARSE_TICKS_PER_MT = 10'(COARSE_TICKS / int'(MT_RESET));
    // Resolution codes equal the two low opcode bits.
    typedef enum logic [1:0] {
        RES_FINE = 2'b00,
        RES_EXTRA_FINE = 2'b01,
        RES_COARSE = 2'b11
    } lsc_res_t;
    typedef enum logic [1:0] {
        ST_DOWN = 2'b00,
        ST_IDLE = 2'b01,
        ST_MEASURE = 2'b10
    } lsc_state_t;
    typedef enum logic [2:0] {
        L_IDLE = 3'b000,
        L_ADDR = 3'b001,
        L_ACK_ADDR = 3'b010,
        L_WRITE = 3'b011,
        L_ACK_WRITE = 3'b100,
        L_READ = 3'b101,
        L_MASTER_ACK = 3'b110
    } lsc_link_t;
endpackage : lsc_pkg

// ### dv/lsc_i2c_master.sv
// Two-wire bus master model that drives the light sensor's bus pins.
// Assumes the bench resolves the open-drain data wire and passes its level in on i_sda.
module lsc_i2c_master (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 16;

    initial
    begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : pause

    // Data is set while the bus clock is low and sampled in mid high phase.
    task automatic bit_slot(input logic drv_low, output logic seen);
        o_sda_pull = drv_low;
        pause(HALF);
        o_scl = 1'b1;
        pause(HALF / 2);
        seen = i_sda;
        pause(HALF / 2);
        o_scl = 1'b0;
        pause(2);
    endtask : bit_slot

    task automatic start_cond();
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
        pause(HALF);
        o_sda_pull = 1'b1;
        pause(HALF);
        o_scl = 1'b0;
        pause(2);
    endtask : start_cond

    task automatic stop_cond();
        o_sda_pull = 1'b1;
        pause(HALF);
        o_scl = 1'b1;
        pause(HALF);
        o_sda_pull = 1'b0;
        pause(HALF);
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_slot(~b[i], s);
        end
        bit_slot(1'b0, s);
        ack = (s === 1'b0);
    endtask : send_byte

    task automatic recv_byte(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_slot(1'b0, b[i]);
        end
        bit_slot(ack_it, s);
    endtask : recv_byte

    // One opcode per transfer, closed by a stop.
    task automatic write_op(input logic [6:0] addr, input logic [7:0] op, output logic ok);
        logic a1;
        logic a2;
        a2 = 1'b0;
        start_cond();
        send_byte({addr, 1'b0}, a1);
        if (a1)
        begin
            send_byte(op, a2);
        end
        stop_cond();
        ok = a1 & a2;
    endtask : write_op

    // High byte is acknowledged, low byte closes the read.
    task automatic read_res(input logic [6:0] addr, output logic [15:0] r, output logic ok);
        logic [7:0] hi;
        logic [7:0] lo;
        start_cond();
        send_byte({addr, 1'b1}, ok);
        recv_byte(1'b1, hi);
        recv_byte(1'b0, lo);
        stop_cond();
        r = {hi, lo};
    endtask : read_res
endmodule : lsc_i2c_master

// ### dv/light_sensor_command_control_tb.sv
// Self-checking bench of the light sensor command logic, driven over the two-wire bus.
// Assumes the bus master model in lsc_i2c_master and a shortened oscillator divider.
`define LSC_CHECK(got, exp) \
    begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module light_sensor_command_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DIV = 1;
    localparam int CT = 74 * 31;
    localparam int FT = 556 * 31;
    logic sys_clk, link_clk, reset, addr_sel, sda_oe, sda_out, powered, measuring;
    logic scl, sda_pull, sda_wire, ok;
    logic [15:0] light_level, rd;
    logic [6:0] dev;
    int run_len = 0;
    int last_len = 0;
    int bad_count = 0;
    int tests_run = 0;

    lsc_light_sensor_ctrl #(.P_OSC_DIV(DIV)) dut_u (.i_sys_clk(sys_clk), .i_reset(reset),
        .i_link_clk(link_clk), .i_scl(scl), .i_sda_in(sda_wire), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .i_addr_sel(addr_sel), .i_light_level(light_level),
        .o_powered(powered), .o_measuring(measuring));
    lsc_i2c_master m_u (.i_clk(sys_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_pull(sda_pull));
    assign sda_wire = ((sda_oe === 1'b1) ? sda_out : 1'b1) & ~sda_pull;

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end
    // Length of the last completed integration in system cycles.
    always @(posedge sys_clk)
    begin
        if (measuring === 1'b1)
            run_len <= run_len + 1;
        else if (run_len != 0)
        begin
            last_len <= run_len;
            run_len <= 0;
        end
    end

    task automatic give_verdict();
        $display("Compares %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : cycles

    task automatic send_op(input logic [7:0] op);
        m_u.write_op(dev, op, ok);
        `LSC_CHECK(ok, 1'b1)
        cycles(8);
    endtask : send_op

    task automatic read_chk(input logic [15:0] exp);
        m_u.read_res(dev, rd, ok);
        `LSC_CHECK({ok, rd}, {1'b1, exp})
    endtask : read_chk

    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        while (measuring !== 1'b0 && n < lim)
        begin
            cycles(1);
            n++;
        end
        if (n >= lim)
        begin
            bad_count++;
            $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, measuring, 1'b0);
            give_verdict();
        end
        else
        begin
            cycles(2);
        end
    endtask : wait_idle

    task automatic one_shot(input logic [7:0] op, input int ticks, input logic [15:0] exp);
        send_op(op);
        wait_idle(ticks * DIV + 300);
        `LSC_CHECK(powered, 1'b0)
        `LSC_CHECK(last_len >= ticks * DIV - 2 && last_len <= ticks * DIV + 3, 1'b1)
        read_chk(exp);
    endtask : one_shot

    initial
    begin
        reset = 1'b1;
        addr_sel = 1'b0;
        dev = 7'h23;
        light_level = 16'h0159;
        cycles(24);
        reset = 1'b0;
        cycles(20);
        `LSC_CHECK(powered, 1'b0)
        read_chk(16'h0000);
        m_u.write_op(7'h5C, 8'h01, ok);
        `LSC_CHECK({ok, powered}, 2'b00)
        send_op(8'h40);
        send_op(8'h7F);
        one_shot(8'h23, CT, 16'h0098);
        one_shot(8'h20, FT, 16'h009B);
        one_shot(8'h21, FT, 16'h0136);
        send_op(8'h07);
        read_chk(16'h0136);
        send_op(8'h01);
        `LSC_CHECK({powered, measuring}, 2'b10)
        send_op(8'h07);
        read_chk(16'h0000);
        send_op(8'h10);
        `LSC_CHECK(measuring, 1'b1)
        send_op(8'h11);
        send_op(8'h13);
        cycles(CT * DIV + 100);
        read_chk(16'h0098);
        light_level = 16'h0114;
        cycles(CT * DIV + 100);
        read_chk(16'h007C);
        `LSC_CHECK({powered, measuring}, 2'b11)
        send_op(8'h00);
        `LSC_CHECK({powered, measuring}, 2'b00)
        send_op(8'h13);
        reset = 1'b1;
        cycles(24);
        `LSC_CHECK({powered, measuring, sda_oe}, 3'b000)
        reset = 1'b0;
        addr_sel = 1'b1;
        dev = 7'h5C;
        light_level = 16'h0159;
        cycles(20);
        read_chk(16'h0000);
        one_shot(8'h23, 74 * 69, 16'h0158);
        give_verdict();
    end
endmodule : light_sensor_command_control_tb
